// ==== bench/tcg_test_set.sv ====
// Stand-in for the ground test set and the processor facing the timing generator.
// Assumes the bench asks for commands as levels; every pin moves on the falling edge.
module tcg_test_set (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic want_stop,
  input wire logic want_start,
  input wire logic want_alarm,
  input wire logic want_read,
  output logic monitor_stop_cmd,
  output logic monitor_start_cmd,
  output logic alarm_in,
  output logic scaler_readout_strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Command and readout pins
  // ************************************************************
  // Commands are plain levels held for as long as asked, since short ones may miss a
  // twelfth pulse and be ignored.
  always @(negedge mclk or negedge nrst) begin
    if (!nrst) begin
      monitor_stop_cmd <= 1'b0;
      monitor_start_cmd <= 1'b0;
      alarm_in <= 1'b0;
      scaler_readout_strobe <= 1'b0;
    end else begin
      monitor_stop_cmd <= want_stop;
      monitor_start_cmd <= want_start;
      alarm_in <= want_alarm;
      scaler_readout_strobe <= want_read;
    end
  end
endmodule : tcg_test_set

// ==== bench/tcg_timer_test.sv ====
// Self-checking bench for the timing countdown generator.
// Assumes a 100 MHz mclk and the test set stand-in on the command and readout pins.
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); \
  end \
end
module tcg_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic want_stop = 1'b0, want_start = 1'b0, want_alarm = 1'b0, want_read = 1'b0;
  logic monitor_stop_cmd, monitor_start_cmd, alarm_in, scaler_readout_strobe;
  tcg_pkg::tcg_phase_s phase_out;
  tcg_pkg::tcg_ring_s ring_out;
  logic quarter_rate_square_first, quarter_rate_square_second, realtime_scaler_last_stage;
  logic [tcg_pkg::RATE_W-1:0] rate_scaler;
  logic [tcg_pkg::REALTIME_W-1:0] write_lines;
  logic [tcg_pkg::TP_N-1:0] timing_pulses, tp_prev;
  logic monitor_halt_stop, restart_stop, global_restart, rd_seen = 1'b0, tp_on = 1'b0;
  logic [15:0] exp_q[$];
  int num_errors = 0, comparisons = 0, tp_idx = 0, hi, per, k, bad;
  // Rate and high time in microseconds of each watched output, in pick order.
  real frq[13] = '{1.024e6, 1.024e6, 1.024e6, 1.024e6, 1.024e6, 1.024e6, 1.024e6,
                   512.0e3, 512.0e3, 102.4e3, 102.4e3, 51.2e3, 6.4e3};
  real wid[13] = '{0.25, 0.25, 0.25, 0.5, 0.5, 0.25, 0.75, 0.9765625, 0.9765625,
                   4.8828125, 2.9296875, 9.765625, 78.125};

  always #5 mclk = ~mclk;

  tcg_test_set tcg_test_set_inst (.mclk(mclk), .nrst(nrst), .want_stop(want_stop),
    .want_start(want_start), .want_alarm(want_alarm), .want_read(want_read),
    .monitor_stop_cmd(monitor_stop_cmd), .monitor_start_cmd(monitor_start_cmd),
    .alarm_in(alarm_in), .scaler_readout_strobe(scaler_readout_strobe));

  tcg_timer tcg_timer_inst (.mclk(mclk), .nrst(nrst), .monitor_stop_cmd(monitor_stop_cmd),
    .monitor_start_cmd(monitor_start_cmd), .alarm_in(alarm_in),
    .scaler_readout_strobe(scaler_readout_strobe), .phase_out(phase_out),
    .ring_out(ring_out), .quarter_rate_square_first(quarter_rate_square_first),
    .quarter_rate_square_second(quarter_rate_square_second), .rate_scaler(rate_scaler),
    .realtime_scaler_last_stage(realtime_scaler_last_stage), .write_lines(write_lines),
    .timing_pulses(timing_pulses), .monitor_halt_stop(monitor_halt_stop),
    .restart_stop(restart_stop), .global_restart(global_restart));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic pick(input int sel);
    case (sel)
      0: return phase_out.first_gated_advance_pulse;
      1: return phase_out.second_gated_advance_pulse;
      2: return phase_out.phase_four_pulse;
      3: return phase_out.half_rate_square_first;
      4: return phase_out.half_rate_square_second;
      5: return phase_out.strobe_short;
      6: return phase_out.strobe_long;
      7: return quarter_rate_square_first;
      8: return quarter_rate_square_second;
      9: return ring_out.phase[0];
      10: return ring_out.strobe[0];
      11: return rate_scaler[0];
      default: return rate_scaler[3];
    endcase
  endfunction : pick

  function automatic logic near(input int got, input real exp, input int tol);
    return (got >= exp - tol) && (got <= exp + tol);
  endfunction : near

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  // Waits a bounded number of cycles for a chosen output level.
  task automatic wait_lvl(input int sel, input logic lvl, input int lim);
    k = 0;
    while (pick(sel) !== lvl && k < lim) begin
      tick();
      k++;
    end
  endtask : wait_lvl

  // Counts the high time of the first period and the length of two whole periods.
  task automatic measure(input int sel);
    hi = 0;
    per = 0;
    wait_lvl(sel, 1'b0, 20000);
    wait_lvl(sel, 1'b1, 20000);
    for (int p = 0; p < 2; p++) begin
      while (pick(sel) === 1'b1) begin
        tick();
        per++;
        if (p == 0) hi++;
      end
      while (pick(sel) === 1'b0) begin
        tick();
        per++;
      end
    end
  endtask : measure

  task automatic close_out();
    $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // ************************************************************
  // Watchers
  // ************************************************************
  // Readout words come one cycle after each strobe cycle and read zero otherwise.
  always @(posedge mclk) begin
    #1;
    if (rd_seen) begin
      `CHK(write_lines, exp_q.pop_front())
    end else if (nrst) begin
      `CHK(write_lines, 16'h0000)
    end
    rd_seen = scaler_readout_strobe;
    if (tp_on && timing_pulses !== 12'h000 && timing_pulses !== tp_prev) begin
      tp_idx = (tp_idx + 1) % tcg_pkg::TP_N;
      `CHK(timing_pulses, 12'h001 << tp_idx)
      tp_prev = timing_pulses;
    end
  end

  initial begin
    #950_000;
    num_errors++;
    close_out();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'h8736));
    repeat (10) @(negedge mclk);
    `CHK(phase_out.strobe_long, 1'b1)
    `CHK(timing_pulses, 12'h001)
    tp_prev = 12'h001;
    tp_on = 1'b1;
    nrst <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      measure(i);
      `CHK({near(hi, wid[i] * 100.0, 2), near(per, 2.0e8 / frq[i], 3)}, 2'h3)
    end
    // Readout with a random strobe pattern, back to back cycles included.
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk);
      k = $urandom % 2;
      want_read <= k[0];
      if (k[0]) exp_q.push_back(16'h0000);
    end
    @(negedge mclk);
    want_read <= 1'b0;
    repeat (3) tick();
    `CHK(exp_q.size(), 0)
    `CHK(realtime_scaler_last_stage, 1'b0)
    // A monitor stop halts the sequence at the twelfth pulse, then resumes with the rest of the twelfth and then the first.
    tp_on = 1'b0;
    repeat ($urandom % 50) @(negedge mclk);
    want_stop <= 1'b1;
    k = 0;
    while (monitor_halt_stop !== 1'b1 && k < 3000) begin
      tick();
      k++;
    end
    `CHK({monitor_halt_stop, restart_stop}, 2'h2)
    bad = 0;
    repeat (400) begin
      tick();
      if (phase_out.first_gated_advance_pulse !== 1'b0 || timing_pulses !== 12'h000) bad++;
    end
    `CHK(bad, 0)
    @(negedge mclk);
    want_stop <= 1'b0;
    k = 0;
    while ((monitor_halt_stop !== 1'b0 || timing_pulses === 12'h000) && k < 600) begin
      tick();
      k++;
    end
    // The halt lands midway through the twelfth pulse, so its other half shows first.
    `CHK({monitor_halt_stop, timing_pulses}, 13'h0800)
    k = 0;
    while (timing_pulses === 12'h800 && k < 200) begin
      tick();
      k++;
    end
    `CHK(timing_pulses, 12'h001)
    // Monitor start, then alarm, each lead to a long global restart.
    for (int j = 0; j < 2; j++) begin
      @(negedge mclk);
      want_start <= (j == 0);
      want_alarm <= (j == 1);
      k = 0;
      while (restart_stop !== 1'b1 && k < 3000) begin
        tick();
        k++;
      end
      `CHK({restart_stop, phase_out.first_gated_advance_pulse}, 2'h2)
      tick();
      `CHK(global_restart, 1'b1)
      @(negedge mclk);
      want_start <= 1'b0;
      want_alarm <= 1'b0;
      k = 0;
      while (global_restart === 1'b1 && k < 5000) begin
        tick();
        k++;
      end
      `CHK(k >= 1160 && k < 5000, 1'b1)
    end
    // A second reset in mid-run brings every count back to its start.
    @(negedge mclk);
    nrst <= 1'b0;
    tick();
    `CHK({timing_pulses, rate_scaler, global_restart, phase_out.strobe_long}, 31'h0008_0001)
    @(negedge mclk);
    nrst <= 1'b1;
    repeat (5) tick();
    `CHK({timing_pulses, phase_out.strobe_long, global_restart}, 14'h0006)
    close_out();
  end
endmodule : tcg_timer_test

// ==== logic/tcg_pkg.sv ====
// Constants, carrier structs and gray-code helpers for the timing countdown generator.
// Assumes a single 100 MHz system clock; the 2.048 mc source is synthesised from it.
package tcg_pkg;

  // ************************************************************
  // Rates and widths
  // ************************************************************
  localparam longint SRC_HZ = 2048000;
  localparam longint MCLK_HZ = 100000000;
  localparam int ACC_W = 24;
  localparam longint ACC_ONE = 64'h0000000001000000;
  // Accumulator step for one source half cycle, that is 4.096 million ticks per second.
  localparam logic [ACC_W-1:0] TICK_STEP = ACC_W'((2 * SRC_HZ * ACC_ONE) / MCLK_HZ);
  localparam int RING_N = 5;
  localparam int STROBE_N = 3;
  localparam int RATE_W = 17;
  localparam int REALTIME_W = 16;
  localparam int TP_N = 12;
  localparam int GRAY_W = 4;
  localparam int SYNC_N = 3;
  localparam int TP_LAST = TP_N - 1;
  localparam logic [3:0] RESTART_HOLD = 4'hC;

  // ************************************************************
  // First divider states, as {first flip-flop, second flip-flop}
  // ************************************************************
  localparam logic [1:0] DIV_IDLE = 2'h0;
  localparam logic [1:0] DIV_FIRST = 2'h2;
  localparam logic [1:0] DIV_BOTH = 2'h3;
  localparam logic [1:0] DIV_SECOND = 2'h1;

  localparam logic [GRAY_W-1:0] GRAY_SEQ [TP_N] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h6, 4'h7,
                                                    4'h5, 4'h4, 4'hC, 4'hD, 4'h9, 4'h8};

  typedef struct packed {
    logic first_gated_advance_pulse;
    logic second_gated_advance_pulse;
    logic phase_four_pulse;
    logic half_rate_square_first;
    logic half_rate_square_second;
    logic strobe_short;
    logic strobe_long;
  } tcg_phase_s;

  typedef struct packed {
    logic [RING_N-1:0] phase;
    logic [STROBE_N-1:0] strobe;
  } tcg_ring_s;

  // Next code in the twelve-step cycle; an unlisted code falls back to the start.
  function automatic logic [GRAY_W-1:0] tcg_gray_next(input logic [GRAY_W-1:0] code);
    logic [GRAY_W-1:0] res;
    res = GRAY_SEQ[0];
    for (int i = 0; i < TP_N; i++) begin
      if (GRAY_SEQ[i] == code) begin
        res = GRAY_SEQ[(i + 1) % TP_N];
      end
    end
    return res;
  endfunction : tcg_gray_next

  function automatic logic [TP_N-1:0] tcg_gray_decode(input logic [GRAY_W-1:0] code);
    logic [TP_N-1:0] res;
    res = '0;
    for (int i = 0; i < TP_N; i++) begin
      res[i] = (GRAY_SEQ[i] == code);
    end
    return res;
  endfunction : tcg_gray_decode

endpackage : tcg_pkg

// ==== logic/tcg_timer.sv ====
// Timing countdown generator: source divider chain, ring counter, scalers,
// gray-code time pulse generator and start-stop logic.
// Assumes monitor commands and alarm arrive asynchronously from outside; the readout
// strobe comes from logic on mclk.
//
// Notes on behaviour
// RL1: First divider halves the 2.048 mc source into 1.024 mc pulses and strobes.
// RL2: Advance pulses and phase-four last a quarter period; square waves high half.
// RL3: Short and long strobes gate both square waves; 0.25 and 0.75 microsecond wide.
// RL4: Either stop signal suppresses the first gated advance pulse.
// RL5: No timing pulse without the first advance pulse; sequence steps only on it.
// RL6: Second divider halves 1.024 mc into two 512 kc square waves.
// RL7: Five-stage ring gives five 5 microsecond pulses at 102.4 kc.
// RL8: Three 3 microsecond strobes at 102.4 kc come from the ring outputs.
// RL9: Rate scaler is seventeen divide-by-two stages, 51.2 kc down to 0.78125 cps.
// RL10: Rate scaler first stage clocks from ring phases three and five, then halves.
// RL11: Real-time scaler is sixteen readable stages fed by the last rate stage.
// RL12: Last real-time stage marks 23.3 hour intervals.
// RL13: Twelve timing pulses decode a gray counter stepped by both advance pulses.
// RL14: Monitor start, monitor stop or alarm blocks the timing sequence.
// RL15: Monitor stop at the twelfth pulse raises halt stop and halts the sequence.
// RL16: Withdrawing monitor stop resumes the normal timing sequence.
// RL17: Monitor start or alarm at the twelfth pulse raises restart stop.
// RL18: Restart stop generates the global restart signal.
// RL19: Each divider uses two flip-flops on opposite phases, a quarter cycle apart.
// RL20: First divider feeds the first stage gating forward to block illegal states.
// RL21: Ring phase two rises only with phase one high and phase five low; falls when phase one is low.
// RL22: Readout strobe places all sixteen real-time stages on the write lines.
// RL23: Gray counter steps once per pulse and wraps to all zeros.
// RL24: Everything runs on one clock and clears to a defined state on reset.
// RL25: Global restart holds for at least one full twelve-pulse cycle.
module tcg_timer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic monitor_stop_cmd,
  input wire logic monitor_start_cmd,
  input wire logic alarm_in,
  input wire logic scaler_readout_strobe,
  output tcg_pkg::tcg_phase_s phase_out,
  output tcg_pkg::tcg_ring_s ring_out,
  output logic quarter_rate_square_first,
  output logic quarter_rate_square_second,
  output logic [tcg_pkg::RATE_W-1:0] rate_scaler,
  output logic realtime_scaler_last_stage,
  output logic [tcg_pkg::REALTIME_W-1:0] write_lines,
  output logic [tcg_pkg::TP_N-1:0] timing_pulses,
  output logic monitor_halt_stop,
  output logic restart_stop,
  output logic global_restart
);

  // ************************************************************
  // Source clock synthesis
  // ************************************************************
  // A phase accumulator stands in for the crystal; each tick is one source half cycle,
  // so edges jitter by one mclk period but the long-term rate is exact to the step.
  logic [tcg_pkg::ACC_W-1:0] acc_ff;
  logic [tcg_pkg::ACC_W:0] acc_sum;
  logic src_tick;
  logic src_ff;

  assign acc_sum = {1'b0, acc_ff} + {1'b0, tcg_pkg::TICK_STEP};
  assign src_tick = acc_sum[tcg_pkg::ACC_W];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_ff <= '0;
      src_ff <= 1'b0;
    end else begin
      acc_ff <= acc_sum[tcg_pkg::ACC_W-1:0];
      if (src_tick) begin
        src_ff <= ~src_ff;
      end
    end
  end

  // ************************************************************
  // First divider
  // ************************************************************
  logic [1:0] div1_ff;
  logic neg_tick;
  logic pos_tick;
  logic enter_first;
  logic enter_both;
  logic enter_second;
  logic stop_any;
  logic a1_event;

  assign neg_tick = src_tick & src_ff;
  assign pos_tick = src_tick & ~src_ff;
  assign enter_first = neg_tick & (div1_ff == tcg_pkg::DIV_IDLE);
  assign enter_both = pos_tick & (div1_ff == tcg_pkg::DIV_FIRST);
  assign enter_second = neg_tick & (div1_ff == tcg_pkg::DIV_BOTH);
  assign stop_any = monitor_halt_stop | restart_stop;
  assign a1_event = enter_first & ~stop_any; // RL4 RL5

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div1_ff <= tcg_pkg::DIV_IDLE;
    end else begin
      if (neg_tick) begin
        div1_ff[1] <= ~div1_ff[0]; // RL19 RL20
      end
      if (pos_tick) begin
        div1_ff[0] <= div1_ff[1]; // RL19
      end
    end
  end

  always_comb begin
    phase_out.first_gated_advance_pulse = (div1_ff == tcg_pkg::DIV_FIRST) & ~stop_any; // RL1 RL2 RL4
    phase_out.second_gated_advance_pulse = (div1_ff == tcg_pkg::DIV_SECOND); // RL2
    phase_out.phase_four_pulse = (div1_ff == tcg_pkg::DIV_BOTH); // RL2
    phase_out.half_rate_square_first = div1_ff[1]; // RL2
    phase_out.half_rate_square_second = div1_ff[0]; // RL2
    phase_out.strobe_short = div1_ff[1] & ~div1_ff[0]; // RL3
    phase_out.strobe_long = ~div1_ff[1] | div1_ff[0]; // RL3
  end

  // ************************************************************
  // Second divider, stepped at the start of the first and second advance pulses
  // ************************************************************
  logic [1:0] div2_ff;
  logic ring_step;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div2_ff <= tcg_pkg::DIV_IDLE;
    end else begin
      if (enter_second) begin
        div2_ff[1] <= ~div2_ff[0]; // RL6 RL19
      end
      if (enter_first) begin
        div2_ff[0] <= div2_ff[1]; // RL6 RL19
      end
    end
  end

  assign quarter_rate_square_first = div2_ff[1];
  assign quarter_rate_square_second = div2_ff[0];
  // Both edges of the first 512 kc wave step the ring, giving 1 microsecond spacing.
  assign ring_step = enter_second & (div2_ff[1] == div2_ff[0]);

  // ************************************************************
  // Ring counter and strobes
  // ************************************************************
  logic [tcg_pkg::RING_N-1:0] ring_ff;
  logic [tcg_pkg::RING_N-1:0] nxt_ring;

  always_comb begin
    nxt_ring = {ring_ff[tcg_pkg::RING_N-2:0], ~ring_ff[tcg_pkg::RING_N-1]}; // RL7
    nxt_ring[1] = ring_ff[0] & (ring_ff[1] | ~ring_ff[4]); // RL21
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ring_ff <= '0;
    end else if (ring_step) begin
      ring_ff <= nxt_ring; // RL7
    end
  end

  always_comb begin
    ring_out.phase = ring_ff;
    ring_out.strobe[0] = ring_ff[0] & ~ring_ff[3]; // RL8
    ring_out.strobe[1] = ring_ff[1] & ~ring_ff[4]; // RL8
    ring_out.strobe[2] = ring_ff[2] & ring_ff[0]; // RL8
  end

  // ************************************************************
  // Rate and real-time scalers
  // ************************************************************
  logic [tcg_pkg::RATE_W-1:0] rate_ff;
  logic [tcg_pkg::REALTIME_W-1:0] realtime_ff;
  logic [tcg_pkg::REALTIME_W-1:0] write_lines_ff;
  logic rate_tick;

  assign rate_tick = ring_step & ~ring_ff[2] & nxt_ring[2] & ~ring_ff[4]; // RL10

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rate_ff <= '0;
      realtime_ff <= '0;
    end else if (rate_tick) begin
      rate_ff <= rate_ff + 1'b1; // RL9 RL10
      if (&rate_ff) begin
        realtime_ff <= realtime_ff + 1'b1; // RL11 RL12
      end
    end
  end

  // The lines read zero outside the strobe so they can be wired-OR with other sources.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      write_lines_ff <= '0;
    end else begin
      write_lines_ff <= scaler_readout_strobe ? realtime_ff : '0; // RL22
    end
  end

  assign rate_scaler = rate_ff;
  assign realtime_scaler_last_stage = realtime_ff[tcg_pkg::REALTIME_W-1]; // RL12
  assign write_lines = write_lines_ff;

  // ************************************************************
  // Time pulse generator
  // ************************************************************
  logic [tcg_pkg::GRAY_W-1:0] gray_pri_ff;
  logic [tcg_pkg::GRAY_W-1:0] gray_sec_ff;
  logic [tcg_pkg::TP_N-1:0] tp_raw;

  assign tp_raw = tcg_pkg::tcg_gray_decode(gray_sec_ff);
  // The primary stage holds the code after the stored one from each second advance pulse to the next first one; it starts one ahead.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gray_pri_ff <= tcg_pkg::GRAY_SEQ[1];
      gray_sec_ff <= tcg_pkg::GRAY_SEQ[0];
    end else if (global_restart) begin
      gray_pri_ff <= tcg_pkg::GRAY_SEQ[1]; // RL24
      gray_sec_ff <= tcg_pkg::GRAY_SEQ[0]; // RL24
    end else begin
      if (enter_second) begin
        gray_pri_ff <= tcg_pkg::tcg_gray_next(gray_sec_ff); // RL13 RL23
      end
      if (a1_event) begin
        gray_sec_ff <= gray_pri_ff; // RL5 RL13 RL14
      end
    end
  end

  assign timing_pulses = stop_any ? '0 : tp_raw; // RL5
  // ************************************************************
  // Start-stop logic
  // ************************************************************
  // Three stages per pin; a level is accepted only once stages two and three agree.
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic [2:0] pin_s3_ff;
  logic [2:0] pin_ff;
  logic halt_ff;
  logic restart_stop_ff;
  logic global_restart_ff;
  logic [3:0] hold_ff;
  logic at_last_tp;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
      pin_ff <= '0;
    end else begin
      pin_s1_ff <= {alarm_in, monitor_start_cmd, monitor_stop_cmd};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff <= (pin_s2_ff & pin_s3_ff) | (pin_ff & (pin_s2_ff | pin_s3_ff));
    end
  end

  assign at_last_tp = tp_raw[tcg_pkg::TP_LAST];
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      halt_ff <= 1'b0;
    end else if (enter_second) begin
      if (pin_ff[0] & at_last_tp) begin
        halt_ff <= 1'b1; // RL14 RL15
      end else if (!pin_ff[0]) begin
        halt_ff <= 1'b0; // RL16
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      restart_stop_ff <= 1'b0;
      hold_ff <= '0;
    end else if (enter_second) begin
      if ((pin_ff[1] | pin_ff[2]) & at_last_tp & ~restart_stop_ff) begin
        restart_stop_ff <= 1'b1; // RL14 RL17
        hold_ff <= tcg_pkg::RESTART_HOLD; // RL25
      end else if (hold_ff != '0) begin
        hold_ff <= hold_ff - 1'b1; // RL25
      end else if (!(pin_ff[1] | pin_ff[2])) begin
        restart_stop_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      global_restart_ff <= 1'b0;
    end else begin
      global_restart_ff <= restart_stop_ff; // RL18
    end
  end

  assign monitor_halt_stop = halt_ff;
  assign restart_stop = restart_stop_ff;
  assign global_restart = global_restart_ff;
  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_restart_raised;
    $rose(restart_stop_ff);
  endsequence
  sequence s_hold_counted;
    (hold_ff == tcg_pkg::RESTART_HOLD) ##0 restart_stop_ff;
  endsequence

  a_a1_blocked: assert property (stop_any |-> !phase_out.first_gated_advance_pulse) // RL4
    else $error("advance pulse seen while stopped");
  a_tp_gated: assert property (stop_any |-> timing_pulses == '0) // RL5
    else $error("timing pulse while stopped");
  a_strobe_pair: assert property (phase_out.strobe_short |-> !phase_out.strobe_long) // RL3
    else $error("short and long strobes overlap");
  a_gray_step: assert property (a1_event && !global_restart
    |=> gray_sec_ff == tcg_pkg::tcg_gray_next($past(gray_sec_ff))) // RL23
    else $error("gray counter did not step once");
  a_ring_fix: assert property (ring_step && ring_ff[0] && ring_ff[4] && !ring_ff[1]
    |=> !ring_ff[1]) // RL21
    else $error("ring phase two rose with phases one and five high");
  a_halt_t12: assert property (enter_second && pin_ff[0] && at_last_tp
    |=> halt_ff) // RL15
    else $error("halt stop not raised at twelfth pulse");
  a_restart_hold: assert property (s_restart_raised |-> s_hold_counted) // RL25
    else $error("restart hold not loaded");
  a_restart_follow: assert property (restart_stop_ff |=> global_restart_ff) // RL18
    else $error("global restart did not follow restart stop");
  a_readout_lines: assert property (scaler_readout_strobe
    |=> write_lines == $past(realtime_ff)) // RL22
    else $error("write lines do not carry the real-time scaler");
  a_div_quarter: assert property (enter_first |=> div1_ff == tcg_pkg::DIV_FIRST) // RL19
    else $error("first divider left its quarter sequence");

endmodule : tcg_timer
